/* rtl/btsx_exec.sv */
// execution of bit set and bit test-skip instructions over four quarter phases
// Functional notes
// - skip-if-clear skips when bit is 0
// - skip-if-set skips when bit is 1
// - skip discards prefetch, runs no-operation cycle
// - operands: address 0-255, bit 0-7, bank
// - bank bit 0 selects fixed access bank
// - bank bit 1 uses bank-select register
// - bit set forces one bit, flags untouched
`timescale 1ns/100ps
`default_nettype none
module btsx_exec (
    // clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rst,
    // instruction stream, one word per instruction cycle, valid at q1
    input  wire logic [15:0]         instr,
    input  wire logic [3:0]          bank_select_register,
    // data memory read port, data returned by q2
    output logic [11:0]              rd_addr_ff,
    input  wire logic [7:0]          rd_data,
    // data memory write strobe
    output btsx_pkg::btsx_wr_t       wr_ff,
    // pipeline control
    output logic                     flush_ff,
    output logic                     nop_cycle_ff,
    output logic [1:0]               phase_ff
);
    ////////////////////////////////////////////////////////////////////////////
    // helper functions

    // bank number of the fixed access bank for a register address
    function automatic logic [3:0] access_bank(input logic [7:0] f);
        if (f < btsx_pkg::ACCESS_SPLIT) begin
            access_bank = btsx_pkg::ACCESS_LO_BANK;
        end else begin
            access_bank = btsx_pkg::ACCESS_HI_BANK;
        end
    endfunction

    // 12-bit data memory address from the bank bit, the register and the bank number
    function automatic logic [11:0] eff_addr(input logic a, input logic [7:0] f, input logic [3:0] bank);
        if (!a) begin
            eff_addr = {access_bank(f), f};
        end else begin
            eff_addr = {bank, f};
        end
    endfunction

    // the selected bit of a register value
    function automatic logic bit_of(input logic [7:0] data, input logic [2:0] b);
        bit_of = data[b];
    endfunction

    // one-hot mask of the selected bit
    function automatic logic [7:0] bit_mask(input logic [2:0] b);
        bit_mask = 8'h01 << b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // internal state and strobes

    // decoded instruction and register value
    btsx_pkg::btsx_dec_t dec;
    btsx_pkg::btsx_dec_t dec_ff;
    logic [7:0]          data_ff;
    logic                skip_pend_ff;

    // quarter phase enables
    logic                q1_en;
    logic                q2_en;
    logic                q3_en;
    logic                q4_en;

    // per-cycle decisions
    logic                take_instr;
    logic                skip_now;
    logic                set_now;

    btsx_decode u_dec (
        .instr (instr),
        .dec   (dec)
    );

    ////////////////////////////////////////////////////////////////////////////
    // quarter phase divider

    // counts q1 to q4, one quarter per clock
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phase_ff <= btsx_pkg::PHASE_RST;
        end else begin
            phase_ff <= phase_ff + 2'h1;
        end
    end

    // one enable pulse per quarter phase
    always_comb begin
        q1_en = (phase_ff == btsx_pkg::PHASE_Q1);
        q2_en = (phase_ff == btsx_pkg::PHASE_Q2);
        q3_en = (phase_ff == btsx_pkg::PHASE_Q3);
        q4_en = (phase_ff == btsx_pkg::PHASE_Q4);
    end

    ////////////////////////////////////////////////////////////////////////////
    // q1: decode and latch operands

    // the word prefetched during a taken skip is dropped
    always_comb begin
        take_instr = q1_en && !skip_pend_ff;
    end

    // operand fields of the instruction taken, none for a dropped word
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dec_ff <= '0;
        end else if (q1_en) begin
            if (take_instr) begin
                dec_ff <= dec;
            end else begin
                dec_ff <= '0;
            end
        end
    end

    // effective address, held through the instruction cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_addr_ff <= '0;
        end else if (take_instr) begin
            rd_addr_ff <= eff_addr(dec.bank_sel, dec.addr, bank_select_register);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // q2: read register f

    // rd_data has to be settled at this edge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            data_ff <= '0;
        end else if (q2_en) begin
            data_ff <= rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // q3: process data

    // skip decision of the bit tests
    always_comb begin
        skip_now = 1'b0;
        unique case (dec_ff.op)
            btsx_pkg::BTSX_OP_SKC: begin
                skip_now = !bit_of(data_ff, dec_ff.bit_sel);
            end
            btsx_pkg::BTSX_OP_SKS: begin
                skip_now = bit_of(data_ff, dec_ff.bit_sel);
            end
            btsx_pkg::BTSX_OP_SET: begin
                skip_now = 1'b0;
            end
            btsx_pkg::BTSX_OP_NONE: begin
                skip_now = 1'b0;
            end
        endcase
    end

    // bit set writes back at the end of q3
    always_comb begin
        set_now = q3_en && (dec_ff.op == btsx_pkg::BTSX_OP_SET);
    end

    // skip decision held from q3 until the next q1
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            skip_pend_ff <= 1'b0;
        end else if (q3_en) begin
            skip_pend_ff <= skip_now;
        end else if (q1_en) begin
            skip_pend_ff <= 1'b0;
        end
    end

    // write register f for bit set, seen during q4; status is left alone
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_ff <= '0;
        end else if (set_now) begin
            wr_ff.addr <= rd_addr_ff;
            wr_ff.data <= data_ff | bit_mask(dec_ff.bit_sel);
            wr_ff.we   <= 1'b1;
        end else begin
            wr_ff.we   <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // q4: pipeline control

    // one-clock request to drop the prefetched word
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flush_ff <= 1'b0;
        end else if (q4_en) begin
            flush_ff <= skip_pend_ff;
        end else begin
            flush_ff <= 1'b0;
        end
    end

    // marks the whole instruction cycle run as a no-operation
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            nop_cycle_ff <= 1'b0;
        end else if (q1_en) begin
            nop_cycle_ff <= skip_pend_ff;
        end
    end
endmodule // btsx_exec
`default_nettype wire

/* rtl/btsx_pkg.sv */
// package for the bit test / bit set execution block
`default_nettype none
package btsx_pkg;
    // opcode prefixes, instruction bits 15:12
    localparam logic [3:0] OPC_BIT_SET_FILE       = 4'h8;
    localparam logic [3:0] OPC_BIT_TEST_SKIP_CLEAR = 4'hb;
    localparam logic [3:0] OPC_BIT_TEST_SKIP_SET   = 4'ha;
    // field positions
    localparam int OPC_LSB  = 12;
    localparam int BIT_LSB  = 9;
    localparam int BANK_POS = 8;
    localparam int ADDR_LSB = 0;
    // access bank split: low addresses map to bank 0, high to the last bank
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
    // quarter phase codes
    localparam logic [1:0] PHASE_RST = 2'h0;
    localparam logic [1:0] PHASE_Q1  = 2'h0;
    localparam logic [1:0] PHASE_Q2  = 2'h1;
    localparam logic [1:0] PHASE_Q3  = 2'h2;
    localparam logic [1:0] PHASE_Q4  = 2'h3;

    typedef enum logic [1:0] {BTSX_OP_NONE, BTSX_OP_SET, BTSX_OP_SKC, BTSX_OP_SKS} btsx_op_t;

    typedef struct packed {
        btsx_op_t   op;
        logic [2:0] bit_sel;
        logic       bank_sel;
        logic [7:0] addr;
    } btsx_dec_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  data;
        logic        we;
    } btsx_wr_t;
endpackage
`default_nettype wire

/* rtl/btsx_decode.sv */
// instruction word decoder for the bit instructions
`timescale 1ns/100ps
`default_nettype none
module btsx_decode (
    // instruction
    input  wire logic [15:0]        instr,
    // decoded fields
    output btsx_pkg::btsx_dec_t     dec
);
    always_comb begin
        dec.bit_sel  = instr[btsx_pkg::BIT_LSB +: 3];
        dec.bank_sel = instr[btsx_pkg::BANK_POS];
        dec.addr     = instr[btsx_pkg::ADDR_LSB +: 8];
        unique case (instr[btsx_pkg::OPC_LSB +: 4])
            btsx_pkg::OPC_BIT_SET_FILE:        dec.op = btsx_pkg::BTSX_OP_SET;
            btsx_pkg::OPC_BIT_TEST_SKIP_CLEAR: dec.op = btsx_pkg::BTSX_OP_SKC;
            btsx_pkg::OPC_BIT_TEST_SKIP_SET:   dec.op = btsx_pkg::BTSX_OP_SKS;
            default:                           dec.op = btsx_pkg::BTSX_OP_NONE;
        endcase
    end
endmodule // btsx_decode
`default_nettype wire

/* sim/btsx_monitor.sv */
// assertion checker for the bit instruction execution block
`timescale 1ns/100ps
`default_nettype none
module btsx_monitor (
    // clock and reset
    input wire logic               ref_clk,
    input wire logic               rst,
    // inputs of the execution block
    input wire logic [15:0]        instr,
    input wire logic [3:0]         bank_select_register,
    input wire logic [7:0]         rd_data,
    // outputs of the execution block
    input wire logic [11:0]        rd_addr_ff,
    input wire btsx_pkg::btsx_wr_t wr_ff,
    input wire logic               flush_ff,
    input wire logic               nop_cycle_ff,
    input wire logic [1:0]         phase_ff
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // a bit instruction taken at q1
    wire q1 = phase_ff == 2'h0 && !flush_ff && (instr[15:12] == 4'h8 || instr[15:13] == 3'b101);
    wire [11:0] ea = {instr[8] ? bank_select_register : {4{instr[7]}}, instr[7:0]};
    a_phase_step: assert property (1 |=> phase_ff == $past(phase_ff) + 2'h1) else $error("phase skip");
    a_read_addr: assert property (q1 |=> rd_addr_ff == $past(ea)) else $error("bad address");
    a_set_write: assert property (q1 && instr[15:12] == 4'h8 |-> ##3 wr_ff.we && wr_ff.addr == $past(ea, 3)
        && wr_ff.data == ($past(rd_data, 2) | 8'h01 << $past(instr[11:9], 3))) else $error("bad bit set");
    a_write_phase: assert property (wr_ff.we |-> phase_ff == 2'h3 && !nop_cycle_ff) else $error("stray write");
    a_skip_flush: assert property (phase_ff == 2'h0 && !$past(rst) && !$past(rst, 4)
        && $past(q1, 4) && $past(instr[13], 4) |-> flush_ff ==
        ((($past(rd_data, 3) >> $past(instr[11:9], 4)) & 8'h01) != {7'h0, $past(instr[12], 4)})) else $error("bad skip");
    a_flush_cause: assert property (flush_ff |-> phase_ff == 2'h0 && $past(instr[15:13], 4) == 3'b101)
        else $error("stray flush");
    a_flush_nop: assert property (flush_ff |=> nop_cycle_ff [*4]) else $error("short nop");
    a_nop_cause: assert property ($rose(nop_cycle_ff) |-> $past(flush_ff)) else $error("stray nop");
endmodule // btsx_monitor
bind btsx_exec btsx_monitor u_mon (.ref_clk, .rst, .instr, .bank_select_register, .rd_addr_ff, .rd_data, .wr_ff,
    .flush_ff, .nop_cycle_ff, .phase_ff);
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench for the bit instruction execution block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic ref_clk = 0, rst = 1, flush_ff, nop_cycle_ff, skp = 0;
    logic [15:0] instr = 0;
    logic [7:0]  rd_data = 0;
    logic [3:0]  bank = 0;
    logic [11:0] rd_addr_ff;
    logic [1:0]  phase_ff;
    btsx_pkg::btsx_wr_t wr_ff;
    int error_cnt = 0, checks_done = 0;
    btsx_exec dut (.ref_clk, .rst, .instr, .bank_select_register(bank), .rd_addr_ff, .rd_data, .wr_ff, .flush_ff,
        .nop_cycle_ff, .phase_ff);
    initial forever #12.5 ref_clk = ~ref_clk;
    task chk(input logic [11:0] a, e);
        checks_done++;
        if (a !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, a, e);
        end
    endtask
    task complete_run;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // expected address: bank bit 1 takes the bank number, 0 the fixed access bank
    function automatic logic [11:0] exp_addr(input logic [15:0] i, input logic [3:0] b);
        if (i[8]) return {b, i[7:0]};
        return {(i[7:0] < btsx_pkg::ACCESS_SPLIT) ? btsx_pkg::ACCESS_LO_BANK : btsx_pkg::ACCESS_HI_BANK, i[7:0]};
    endfunction
    function automatic logic has_op(input logic [15:0] i, input logic [3:0] op);
        return i[15:12] == op;
    endfunction
    function automatic logic exp_skip(input logic [15:0] i, input logic [7:0] d);
        if (has_op(i, btsx_pkg::OPC_BIT_TEST_SKIP_CLEAR)) return !d[i[11:9]];
        if (has_op(i, btsx_pkg::OPC_BIT_TEST_SKIP_SET)) return d[i[11:9]];
        return 1'b0;
    endfunction
    // one instruction cycle, entered at the falling edge before q1
    task run(input logic [15:0] i, input logic [7:0] d);
        logic sk;
        logic st;
        logic tst;
        logic [11:0] ea;
        instr = i;
        bank = 4'($urandom);
        rd_data = d;
        ea = exp_addr(i, bank);
        st = !skp && has_op(i, btsx_pkg::OPC_BIT_SET_FILE);
        tst = has_op(i, btsx_pkg::OPC_BIT_TEST_SKIP_CLEAR) || has_op(i, btsx_pkg::OPC_BIT_TEST_SKIP_SET);
        sk = !skp && exp_skip(i, d);
        @(negedge ref_clk);
        chk(12'(nop_cycle_ff), 12'(skp));
        chk(12'(phase_ff), 12'h1);
        if (st || (!skp && tst)) chk(rd_addr_ff, ea);
        @(negedge ref_clk);
        rd_data = ~d;
        @(negedge ref_clk);
        chk(12'(wr_ff.we), 12'(st));
        if (st) chk({wr_ff.data, 4'h0}, {d | 8'h01 << i[11:9], 4'h0});
        if (st) chk(wr_ff.addr, ea);
        @(negedge ref_clk);
        chk(12'(flush_ff), 12'(sk));
        skp = sk;
    endtask
    initial begin
        void'($urandom(32'h02ce));
        repeat (8) @(negedge ref_clk);
        rst = 0;
        run({4'hb, 3'd7, 1'b0, 8'h80}, 8'h7f);
        run({4'h8, 3'd2, 1'b1, 8'h10}, 8'h00);
        run({4'ha, 3'd0, 1'b0, 8'h7f}, 8'h01);
        run({4'ha, 3'd0, 1'b1, 8'h00}, 8'h01);
        run({4'h8, 3'd7, 1'b1, 8'hff}, 8'h0a);
        repeat (300) run({4'h8 | 4'($urandom % 4), 12'($urandom)}, 8'($urandom));
        complete_run;
    end
    initial begin
        #60000;
        error_cnt++;
        complete_run;
    end
endmodule // testbench
`default_nettype wire
